// ---- include/pcs_defines.svh ----
// Constants for the phrase code serial input block: timing, codes, ROM map.
// Assumes the core clock runs at the rate given here; included by bare name.
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// Core clock rate in hertz
`define PCS_CLK_FREQ_HZ 25000000
// Least start bit width in nanoseconds
`define PCS_START_MIN_NS 1000
// Least start bit width in core cycles, rounded up
`define PCS_START_CYCLES ((`PCS_START_MIN_NS * (`PCS_CLK_FREQ_HZ / 1000000) + 999) / 1000)
// Width of the start bit timer
`define PCS_START_CNT_W 8

// Phrase code width and bit counter width
`define PCS_CODE_BITS 8
`define PCS_BIT_CNT_W 3
`define PCS_LAST_BIT 3'h7

// Code map
`define PCS_CODE_STOP 8'h00
`define PCS_CODE_LAST_PHRASE 8'hF7
`define PCS_MAX_PHRASES 247

// ROM map, byte addresses
`define PCS_ROM_AW 19
`define PCS_TABLE_FIRST 19'h0_0000
`define PCS_TABLE_LAST 19'h0_07C7
`define PCS_USER_FIRST 19'h0_07C8
`define PCS_USER_LAST 19'h5_FFFC
`define PCS_TEST_FIRST 19'h5_FFFD
`define PCS_TEST_LAST 19'h5_FFFF
// Bytes per phrase control table entry, as a shift
`define PCS_ENTRY_SHIFT 3

// Nominal external clock of each build, in kHz
`define PCS_FREQ_LOW_KHZ 15'h1000
`define PCS_FREQ_MID_KHZ 15'h2000
`define PCS_FREQ_HIGH_KHZ 15'h4000

`endif

// ---- include/pcs_pkg.sv ----
// Types shared by the phrase code serial input block.
// Assumes pcs_defines.svh sits on the include path.
`include "pcs_defines.svh"

package pcs_pkg;

   // Build options: A to C strobe framing, D to F start bit framing
   typedef enum logic [2:0] {
      PCS_OPT_A,
      PCS_OPT_B,
      PCS_OPT_C,
      PCS_OPT_D,
      PCS_OPT_E,
      PCS_OPT_F
   } pcs_option_t;

   // Meaning of a received code
   typedef enum logic [1:0] {
      PCS_CLS_STOP,
      PCS_CLS_PHRASE,
      PCS_CLS_TEST
   } pcs_code_class_t;

   // Entry framing state
   typedef enum logic [1:0] {
      PCS_ENT_IDLE,
      PCS_ENT_ARMED,
      PCS_ENT_DONE
   } pcs_entry_state_t;

   // ROM area of a fetch address
   typedef enum logic [1:0] {
      PCS_AREA_TABLE,
      PCS_AREA_USER,
      PCS_AREA_TEST
   } pcs_rom_area_t;

   // A decoded phrase command
   typedef struct packed {
      logic [`PCS_CODE_BITS-1:0] code;
      pcs_code_class_t cls;
      logic [`PCS_ROM_AW-1:0] table_addr;
   } pcs_cmd_t;

endpackage : pcs_pkg

// ---- logic/pcs_link_shift.sv ----
// Serial clock domain front of the phrase code input: shift register and bit event.
// Assumes the serial clock is made by the host and may stand still between entries.
`timescale 1ns/1ps

module pcs_link_shift (
   input wire logic ser_clk,
   input wire logic rst_n,
   input wire logic data_in,
   output logic [`PCS_CODE_BITS-1:0] shift_word,
   output logic bit_toggle
);

   logic [`PCS_CODE_BITS-1:0] shift_q;
   logic [`PCS_CODE_BITS-1:0] shift_d;
   logic tog_q;
   logic tog_d;

   // MSB first, so each new bit enters at the bottom
   always_comb begin
      shift_d = {shift_q[`PCS_CODE_BITS-2:0], data_in};
      tog_d = ~tog_q;
   end

   // Falling edge: data is stable here by its setup and hold
   // Reset is asynchronous since this clock may not run while reset is held
   always_ff @(negedge ser_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q <= 8'h00;
         tog_q <= 1'b0;
      end else begin
         shift_q <= shift_d;
         tog_q <= tog_d;
      end
   end

   assign shift_word = shift_q;
   assign bit_toggle = tog_q;

endmodule : pcs_link_shift

// ---- logic/pcs_rom_guard.sv ----
// Classifies a playback fetch address against the ROM map and gates user fetches.
// Assumes the address comes from core clock logic; outputs are registered.
`timescale 1ns/1ps

module pcs_rom_guard (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [`PCS_ROM_AW-1:0] fetch_addr,
   output logic fetch_ok,
   output pcs_pkg::pcs_rom_area_t fetch_area
);

   logic ok_d;
   logic ok_q;
   pcs_pkg::pcs_rom_area_t area_d;
   pcs_pkg::pcs_rom_area_t area_q;

   // Only the user data area may feed playback; test bytes never do
   always_comb begin
      if (fetch_addr <= `PCS_TABLE_LAST) begin
         area_d = pcs_pkg::PCS_AREA_TABLE;
      end else if (fetch_addr <= `PCS_USER_LAST) begin
         area_d = pcs_pkg::PCS_AREA_USER;
      end else begin
         area_d = pcs_pkg::PCS_AREA_TEST;
      end
      ok_d = (fetch_addr >= `PCS_USER_FIRST) && (fetch_addr <= `PCS_USER_LAST);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ok_q <= 1'b0;
         area_q <= pcs_pkg::PCS_AREA_TABLE;
      end else begin
         ok_q <= ok_d;
         area_q <= area_d;
      end
   end

   assign fetch_ok = ok_q;
   assign fetch_area = area_q;

endmodule : pcs_rom_guard

// ---- logic/pcs_phrase_code_serial_input.sv ----
// Phrase code serial input: framing, capture, decode and code latch.
// Assumes a free running core clock, a host made serial clock, and that
// the pins are asynchronous to the core clock.
`timescale 1ns/1ps

// Summary of operation
// - Only the first eight pulses of an entry count; extra pulses ignored.
// - Code zero stops; codes 01 to F7 each select one playback phrase.
// - At most 247 phrases, each at its own nonzero code.
// - ROM bytes 5FFFD to 5FFFF hold test data, never fetched for playback.
// - Table from 0 to 007C7, user data 007C8 to 5FFFC.
// - Build option fixes framing style and nominal external clock.
// - Start bit builds accept bits only after data held low one microsecond.
// - Code is captured on the eighth serial falling edge after framing.
// - Latch empty flag high when empty and after reset.
// - A new start bit before the eighth clock restarts the entry.
// - Strobe builds count bits only while strobe is low; high cancels.
// - Stop code halts playback at the falling edge after its last bit.
module pcs_phrase_code_serial_input #(
   parameter pcs_pkg::pcs_option_t OPTION = pcs_pkg::PCS_OPT_D
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic phrase_serial_clk,
   input wire logic phrase_serial_in,
   input wire logic entry_strobe_n,
   input wire logic phrase_taken,
   input wire logic [`PCS_ROM_AW-1:0] user_fetch_addr,
   output logic code_latch_empty,
   output pcs_pkg::pcs_cmd_t phrase_cmd,
   output logic stop_req,
   output logic test_code_seen,
   output logic fetch_ok,
   output pcs_pkg::pcs_rom_area_t fetch_area,
   output logic [14:0] nominal_clk_khz
);

   // Build option decode, fixed at elaboration
   localparam logic TWO_PIN = (OPTION == pcs_pkg::PCS_OPT_D) ||
                              (OPTION == pcs_pkg::PCS_OPT_E) ||
                              (OPTION == pcs_pkg::PCS_OPT_F);
   localparam logic [`PCS_START_CNT_W-1:0] START_LAST =
      `PCS_START_CNT_W'(`PCS_START_CYCLES - 1);

   // Nominal external clock reported for the chosen build
   always_comb begin
      unique case (OPTION)
         pcs_pkg::PCS_OPT_A, pcs_pkg::PCS_OPT_D: nominal_clk_khz = `PCS_FREQ_LOW_KHZ;
         pcs_pkg::PCS_OPT_B, pcs_pkg::PCS_OPT_E: nominal_clk_khz = `PCS_FREQ_MID_KHZ;
         default: nominal_clk_khz = `PCS_FREQ_HIGH_KHZ;
      endcase
   end

   // Link domain: shift register and one toggle per serial falling edge
   logic [`PCS_CODE_BITS-1:0] link_word;
   logic link_tog;

   pcs_link_shift u_link (
      .ser_clk(phrase_serial_clk),
      .rst_n(resetn),
      .data_in(phrase_serial_in),
      .shift_word(link_word),
      .bit_toggle(link_tog)
   );

   // Two stage synchronisers for the pins and the bit toggle
   logic sd_m_q;
   logic sd_s_q;
   logic st_m_q;
   logic st_s_q;
   logic tog_m_q;
   logic tog_s_q;
   logic tog_p_q;

   always_ff @(posedge clk) begin
      sd_m_q <= phrase_serial_in;
      sd_s_q <= sd_m_q;
      st_m_q <= entry_strobe_n;
      st_s_q <= st_m_q;
      tog_m_q <= link_tog;
      tog_s_q <= tog_m_q;
   end

   // Edge detector on the synced toggle; reset takes the current level as baseline
   always_ff @(posedge clk) begin
      tog_p_q <= tog_s_q;
   end

   logic bit_event;
   assign bit_event = resetn && (tog_s_q != tog_p_q);

   // Start bit timer: data low with no serial edge for the least width
   logic [`PCS_START_CNT_W-1:0] low_cnt_q;
   logic [`PCS_START_CNT_W-1:0] low_cnt_d;
   logic start_hit;

   always_comb begin
      low_cnt_d = low_cnt_q;
      start_hit = 1'b0;
      if (sd_s_q || bit_event) begin
         low_cnt_d = '0;
      end else if (low_cnt_q < START_LAST) begin
         low_cnt_d = low_cnt_q + 1'b1;
      end else if (low_cnt_q == START_LAST) begin
         // Fires once per low stretch, then the timer parks above the mark
         start_hit = TWO_PIN;
         low_cnt_d = low_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         low_cnt_q <= '0;
      end else begin
         low_cnt_q <= low_cnt_d;
      end
   end

   // Entry framing and bit counting
   pcs_pkg::pcs_entry_state_t ent_q;
   pcs_pkg::pcs_entry_state_t ent_d;
   logic [`PCS_BIT_CNT_W-1:0] cnt_q;
   logic [`PCS_BIT_CNT_W-1:0] cnt_d;
   logic capture;

   always_comb begin
      ent_d = ent_q;
      cnt_d = cnt_q;
      capture = 1'b0;
      if (TWO_PIN && start_hit) begin
         // Any start bit restarts the entry, partial or finished
         ent_d = pcs_pkg::PCS_ENT_ARMED;
         cnt_d = '0;
      end else if (!TWO_PIN && st_s_q) begin
         // Strobe high cancels whatever was being entered
         ent_d = pcs_pkg::PCS_ENT_IDLE;
         cnt_d = '0;
      end else begin
         unique case (ent_q)
            pcs_pkg::PCS_ENT_IDLE: begin
               // Bits before framing are ignored
               if (!TWO_PIN) begin
                  ent_d = pcs_pkg::PCS_ENT_ARMED;
                  cnt_d = '0;
               end
            end
            pcs_pkg::PCS_ENT_ARMED: begin
               if (bit_event) begin
                  if (cnt_q == `PCS_LAST_BIT) begin
                     capture = 1'b1;
                     ent_d = pcs_pkg::PCS_ENT_DONE;
                  end
                  cnt_d = cnt_q + 1'b1;
               end
            end
            pcs_pkg::PCS_ENT_DONE: begin
               // Pulses beyond the eighth are dropped until new framing
               ent_d = pcs_pkg::PCS_ENT_DONE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ent_q <= pcs_pkg::PCS_ENT_IDLE;
         cnt_q <= '0;
      end else begin
         ent_q <= ent_d;
         cnt_q <= cnt_d;
      end
   end

   // Decode of the captured word; the link word stays still until the next fall
   pcs_pkg::pcs_code_class_t cls_now;

   always_comb begin
      if (link_word == `PCS_CODE_STOP) begin
         cls_now = pcs_pkg::PCS_CLS_STOP;
      end else if (link_word <= `PCS_CODE_LAST_PHRASE) begin
         cls_now = pcs_pkg::PCS_CLS_PHRASE;
      end else begin
         cls_now = pcs_pkg::PCS_CLS_TEST;
      end
   end

   // Code latch, pulses and empty flag
   pcs_pkg::pcs_cmd_t cmd_q;
   pcs_pkg::pcs_cmd_t cmd_d;
   logic empty_q;
   logic empty_d;
   logic stop_q;
   logic stop_d;
   logic test_q;
   logic test_d;

   always_comb begin
      cmd_d = cmd_q;
      empty_d = empty_q;
      stop_d = 1'b0;
      test_d = 1'b0;
      if (phrase_taken) begin
         empty_d = 1'b1;
      end
      if (capture) begin
         unique case (cls_now)
            pcs_pkg::PCS_CLS_STOP: begin
               stop_d = 1'b1;
            end
            pcs_pkg::PCS_CLS_PHRASE: begin
               cmd_d.code = link_word;
               cmd_d.cls = cls_now;
               // Table entry per code; code F7 ends below the table top
               cmd_d.table_addr = `PCS_ROM_AW'({11'h000, link_word} << `PCS_ENTRY_SHIFT);
               // Capture wins over a same cycle take
               empty_d = 1'b0;
            end
            pcs_pkg::PCS_CLS_TEST: begin
               test_d = 1'b1;
            end
            default: begin
               test_d = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cmd_q <= '0;
         empty_q <= 1'b1;
         stop_q <= 1'b0;
         test_q <= 1'b0;
      end else begin
         cmd_q <= cmd_d;
         empty_q <= empty_d;
         stop_q <= stop_d;
         test_q <= test_d;
      end
   end

   assign phrase_cmd = cmd_q;
   assign code_latch_empty = empty_q;
   assign stop_req = stop_q;
   assign test_code_seen = test_q;

   // Fetch guard keeps playback inside the user data area
   pcs_rom_guard u_guard (
      .clk(clk),
      .resetn(resetn),
      .fetch_addr(user_fetch_addr),
      .fetch_ok(fetch_ok),
      .fetch_area(fetch_area)
   );

endmodule : pcs_phrase_code_serial_input

// ---- sim/pcs_host_model.sv ----
// Host controller model: drives phrase entries on serial clock and data.
// Assumes the data line rests high and the serial clock stands low.
`timescale 1ns/1ps

module pcs_host_model (
   output logic sclk,
   output logic sdata
);
   // Line rests high: a resting low would frame an entry
   initial begin
      sclk = 1'h0;
      sdata = 1'h1;
   end

   // Low for over a microsecond with no clock frames an entry
   task automatic start_bit();
      sdata = 1'h0;
      #1200;
   endtask : start_bit

   // MSB first, one bit per pulse; extra pulses toggle
   // Falls 800 ns apart so a run of zeros never looks like framing
   task automatic send(input logic [7:0] c, input int n);
      for (int i = 0; i < n; i++) begin
         sdata = (i < 8) ? c[7 - i] : ~sdata;
         #100;
         sclk = 1'h1;
         #350;
         sclk = 1'h0;
         #350;
      end
      sdata = 1'h1;
   endtask : send
endmodule : pcs_host_model

// ---- sim/pcs_serial_asserts.sv ----
// Checker for the phrase code input: capture timing, decode, latch, fetch map.
// Assumes binding to the top module; all checks in the core clock domain.
`timescale 1ns/1ps
`include "pcs_defines.svh"

module pcs_serial_asserts (
   input wire logic clk,
   input wire logic resetn,
   input wire logic phrase_serial_clk,
   input wire logic phrase_taken,
   input wire logic [`PCS_ROM_AW-1:0] user_fetch_addr,
   input wire logic code_latch_empty,
   input wire pcs_pkg::pcs_cmd_t phrase_cmd,
   input wire logic stop_req,
   input wire logic test_code_seen,
   input wire logic fetch_ok,
   input wire pcs_pkg::pcs_rom_area_t fetch_area,
   input wire logic [14:0] nominal_clk_khz
);
   logic [3:0] age_q;
   logic [3:0] age_d;
   logic sclk_q;
   logic sclk_d;

   // Cycles since a serial fall was sampled, saturating at 15
   always_comb begin
      sclk_d = phrase_serial_clk;
      age_d = (sclk_q && !phrase_serial_clk) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
      if (!resetn) begin
         age_d = 4'hF;
      end
   end
   always_ff @(posedge clk) begin
      sclk_q <= sclk_d;
      age_q <= age_d;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence capture_s;
      $fell(code_latch_empty) || stop_req || test_code_seen;
   endsequence
   sequence take_s;
      phrase_taken ##1 $stable(phrase_cmd);
   endsequence

   a_capture_near_fall: assert property (capture_s |-> age_q inside {[4'h1:4'h8]})
      else $error("capture not tied to a serial fall");
   a_phrase_decode: assert property ($fell(code_latch_empty) |->
      phrase_cmd.cls == pcs_pkg::PCS_CLS_PHRASE && phrase_cmd.code inside {[8'h01:8'hF7]})
      else $error("latch filled by a non phrase code");
   a_table_entry: assert property ($changed(phrase_cmd) |->
      phrase_cmd.table_addr == {phrase_cmd.code, 3'h0})
      else $error("table address does not follow code");
   a_stop_one_cycle: assert property (stop_req |=> !stop_req)
      else $error("stop pulse too long");
   a_pulse_no_fill: assert property ((stop_req || test_code_seen) |->
      $stable(phrase_cmd) && !(stop_req && test_code_seen))
      else $error("stop or test code touched the latch");
   a_taken_empties: assert property (take_s |-> code_latch_empty)
      else $error("latch not emptied after take");
   a_fetch_user: assert property ($past(resetn) |-> fetch_ok ==
      ($past(user_fetch_addr) inside {[`PCS_USER_FIRST:`PCS_USER_LAST]}))
      else $error("fetch gate wrong for address");
   a_fetch_test_area: assert property ($past(resetn) && $past(user_fetch_addr) >=
      `PCS_TEST_FIRST |-> fetch_area == pcs_pkg::PCS_AREA_TEST && !fetch_ok)
      else $error("test area fetch let through");
   a_freq_const: assert property ($stable(nominal_clk_khz) && nominal_clk_khz inside
      {`PCS_FREQ_LOW_KHZ, `PCS_FREQ_MID_KHZ, `PCS_FREQ_HIGH_KHZ})
      else $error("nominal clock value wrong");
endmodule : pcs_serial_asserts

bind pcs_phrase_code_serial_input pcs_serial_asserts pcs_serial_asserts_i (.*);

// ---- sim/pcs_phrase_code_serial_input_tb.sv ----
// Testbench for the phrase code serial input in a start bit build and a strobe build.
// Assumes the host model makes serial clock and data on its own timing.
`timescale 1ns/1ps
`include "pcs_defines.svh"

module pcs_phrase_code_serial_input_tb;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic phrase_taken = 1'h0;
   logic [18:0] user_fetch_addr = 19'h0;
   logic sclk, sdata, code_latch_empty, stop_req, test_code_seen, fetch_ok;
   pcs_pkg::pcs_cmd_t phrase_cmd;
   pcs_pkg::pcs_rom_area_t fetch_area;
   logic [14:0] nominal_clk_khz;
   // Second build with strobe framing shares the serial lines and the take
   logic strobe_n = 1'h1;
   logic empty_b;
   pcs_pkg::pcs_cmd_t cmd_b;
   logic [14:0] khz_b;
   int mismatches = 0;
   int check_count = 0;
   int stops = 0;
   int tests = 0;
   int cycles = 0;

   pcs_host_model pcs_host_model_i (.sclk(sclk), .sdata(sdata));
   pcs_phrase_code_serial_input #(.OPTION(pcs_pkg::PCS_OPT_D)) pcs_phrase_code_serial_input_i (
      .clk(clk), .resetn(resetn), .phrase_serial_clk(sclk), .phrase_serial_in(sdata),
      .entry_strobe_n(1'h0),
      .phrase_taken(phrase_taken), .user_fetch_addr(user_fetch_addr),
      .code_latch_empty(code_latch_empty), .phrase_cmd(phrase_cmd), .stop_req(stop_req),
      .test_code_seen(test_code_seen), .fetch_ok(fetch_ok), .fetch_area(fetch_area),
      .nominal_clk_khz(nominal_clk_khz));
   pcs_phrase_code_serial_input #(.OPTION(pcs_pkg::PCS_OPT_B)) pcs_phrase_code_serial_input_b_i (
      .clk(clk), .resetn(resetn), .phrase_serial_clk(sclk), .phrase_serial_in(sdata),
      .entry_strobe_n(strobe_n),
      .phrase_taken(phrase_taken), .user_fetch_addr(user_fetch_addr),
      .code_latch_empty(empty_b), .phrase_cmd(cmd_b), .stop_req(), .test_code_seen(),
      .fetch_ok(), .fetch_area(), .nominal_clk_khz(khz_b));

   // Core clock never stops, or nothing is captured
   initial begin
      forever #20 clk = ~clk;
   end

   // Pulses are one cycle, so count them; also cut a hang short
   always @(posedge clk) begin
      stops <= stops + int'(stop_req === 1'h1);
      tests <= tests + int'(test_code_seen === 1'h1);
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic settle();
      repeat (12) @(posedge clk);
      #1;
   endtask : settle

   task automatic frame(input logic [7:0] c, input int n);
      pcs_host_model_i.start_bit();
      pcs_host_model_i.send(c, n);
      settle();
   endtask : frame

   task automatic take(input logic [7:0] c);
      chk("latch_empty", 1'h0, code_latch_empty);
      chk("code", c, phrase_cmd.code);
      chk("cls", pcs_pkg::PCS_CLS_PHRASE, phrase_cmd.cls);
      chk("table", {c, 3'h0}, phrase_cmd.table_addr);
      phrase_taken = 1'h1;
      @(posedge clk);
      #1;
      phrase_taken = 1'h0;
      @(posedge clk);
      #1;
      chk("latch_empty", 1'h1, code_latch_empty);
   endtask : take

   task automatic t_codes();
      logic [7:0] ph [3] = '{8'h01, 8'h5A, 8'hF7};
      logic [7:0] tc [2] = '{8'hF8, 8'hFF};
      int s;
      foreach (ph[i]) begin
         frame(ph[i], 8);
         take(ph[i]);
      end
      frame(8'hA5, 11);
      take(8'hA5);
      pcs_host_model_i.start_bit();
      pcs_host_model_i.send(8'hFF, 5);
      frame(8'h3C, 8);
      take(8'h3C);
      s = stops;
      frame(8'h00, 8);
      chk("stops", s + 1, stops);
      s = tests;
      foreach (tc[i]) begin
         frame(tc[i], 8);
      end
      chk("tests", s + 2, tests);
      chk("latch_empty", 1'h1, code_latch_empty);
   endtask : t_codes

   // Bits without framing, and bits split by a reset, must both be lost
   task automatic t_unframed();
      pcs_host_model_i.send(8'h66, 8);
      settle();
      chk("latch_empty", 1'h1, code_latch_empty);
      pcs_host_model_i.start_bit();
      pcs_host_model_i.send(8'hF0, 4);
      @(posedge clk);
      #1;
      resetn = 1'h0;
      repeat (3) @(posedge clk);
      #1;
      resetn = 1'h1;
      repeat (3) @(posedge clk);
      pcs_host_model_i.send(8'h0F, 4);
      settle();
      chk("latch_empty", 1'h1, code_latch_empty);
   endtask : t_unframed

   task automatic t_fetch();
      logic [18:0] a [6] = '{19'h0_0000, 19'h0_07C7, 19'h0_07C8, 19'h5_FFFC,
                             19'h5_FFFD, 19'h5_FFFF};
      foreach (a[i]) begin
         user_fetch_addr = a[i];
         @(posedge clk);
         #1;
         chk("fetch_ok", i / 2 == 1, fetch_ok);
         chk("area", i / 2, fetch_area);
      end
   endtask : t_fetch

   // Strobe build: strobe high mid entry drops the partial bits
   task automatic t_strobe();
      chk("latch_empty_b", 1'h1, empty_b);
      strobe_n = 1'h0;
      repeat (4) @(posedge clk);
      #1;
      pcs_host_model_i.send(8'h12, 3);
      strobe_n = 1'h1;
      repeat (4) @(posedge clk);
      #1;
      strobe_n = 1'h0;
      repeat (4) @(posedge clk);
      #1;
      pcs_host_model_i.send(8'h5A, 8);
      settle();
      strobe_n = 1'h1;
      chk("latch_empty_b", 1'h0, empty_b);
      chk("code_b", 8'h5A, cmd_b.code);
      chk("khz_b", `PCS_FREQ_MID_KHZ, khz_b);
   endtask : t_strobe

   task automatic print_verdict();
      if (mismatches == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   initial begin
      repeat (16) @(posedge clk);
      #1;
      resetn = 1'h1;
      repeat (4) @(posedge clk);
      chk("latch_empty", 1'h1, code_latch_empty);
      chk("cmd", 32'h0, phrase_cmd);
      chk("khz", `PCS_FREQ_LOW_KHZ, nominal_clk_khz);
      t_codes();
      t_unframed();
      t_fetch();
      t_strobe();
      print_verdict();
   end
endmodule : pcs_phrase_code_serial_input_tb
